// ### rtl/fft_pkg.sv
// Shared constants, types and width arithmetic for the parallel-lane
// transform datapath.
// Assumes one clock domain and producer and consumer logic on that clock.
//
// Notes on behaviour
// - Unbounded-growth mode never scales; each stage widens by log2(R).
// - The transform is a serial chain of logR(N) radix-R stages.
// - Capped growth widens up to the 27-bit multiplier input, then scales.
// - Per-stage scaling mode shifts each stage right by log2(R) bits.
// - Rotation factors default to 18-bit words with 2 signed integer bits.
// - Rotation word and integer widths are parameters; larger stay correct up to 32-bit words.
// - Hardware carries only complex fixed-point samples, never floats.
// - The output word width follows from the mode, the input widths and the length.
// - Each sample is complex; each part is integer plus fraction bits wide.
// - Blocks are R lanes by N/R time steps on both input and output.
// - The lane count per clock is restricted to 2, 4, 8 or 16.
// - All R lanes of one time step travel together as one stream word.
package fft_pkg;

	// Word growth policy between stages.
	typedef enum logic [1:0]
	{
		unbounded_growth_mode,
		capped_growth_mode,
		per_stage_scaling_mode
	} scaling_type;

	localparam int  MULT_INPUT_BITS   = 27;
	localparam int  ROT_WORD_BITS     = 18;
	localparam int  ROT_INT_BITS      = 2;
	localparam int  DEF_LANES         = 4;
	localparam int  DEF_LENGTH        = 1024;
	localparam int  DEF_INTEGER_BITS  = 8;
	localparam int  DEF_FRACTION_BITS = 8;
	localparam real TWO_PI            = 6.283185307179586;

	// Bits of growth per stage; zero marks an unsupported lane count.
	function automatic int radix_log2(input int lanes);
		unique case (lanes)
			2:       radix_log2 = 1;
			4:       radix_log2 = 2;
			8:       radix_log2 = 3;
			16:      radix_log2 = 4;
			default: radix_log2 = 0;
		endcase
	endfunction : radix_log2

	// Smallest b with 2**b >= n, never below one.
	function automatic int ceil_log2(input int n);
		int b;
		b = 1;
		while ((1 << b) < n)
			b++;
		ceil_log2 = b;
	endfunction : ceil_log2

	// Word width after the given number of stages.
	function automatic int stage_width(input scaling_type mode,
		input int w0, input int lg, input int stages);
		int w;
		w = w0;
		for (int i = 0; i < stages; i++)
		begin
			unique case (mode)
				unbounded_growth_mode:  w = w + lg;
				capped_growth_mode:
					if (w + lg <= MULT_INPUT_BITS)
						w = w + lg;
					else if (w < MULT_INPUT_BITS)
						w = MULT_INPUT_BITS;
				per_stage_scaling_mode: w = w;
			endcase
		end
		stage_width = w;
	endfunction : stage_width

endpackage : fft_pkg

// ### rtl/rotation_table.sv
// Quantised rotation factor lookup, exp(-j*2*pi*index/LENGTH).
// Assumes LENGTH is a power of two equal to 2**IDX_W and TOTAL_BITS <= 32.
`timescale 1ns/1ps
`default_nettype none

module rotation_table
	import fft_pkg::*;
#(
	parameter int LENGTH     = DEF_LENGTH,
	parameter int TOTAL_BITS = ROT_WORD_BITS,
	parameter int INT_BITS   = ROT_INT_BITS,
	parameter int IDX_W      = 10
)
(
	input  wire logic        [IDX_W-1:0]      index,
	output logic signed      [TOTAL_BITS-1:0] cos_part,
	output logic signed      [TOTAL_BITS-1:0] sin_part
);

	// Rounds to nearest; two integer bits let plus one land exactly.
	function automatic logic signed [TOTAL_BITS-1:0] quantise(input real v);
		real sc;
		sc = 2.0 ** (TOTAL_BITS - INT_BITS);
		quantise = TOTAL_BITS'($rtoi(v * sc + ((v < 0.0) ? -0.5 : 0.5)));
	endfunction : quantise

	logic signed [TOTAL_BITS-1:0] cos_rom [LENGTH];
	logic signed [TOTAL_BITS-1:0] sin_rom [LENGTH];

	// Tables are fixed at elaboration, so wider words cost area only.
	for (genvar i = 0; i < LENGTH; i++)
	begin : fill
		assign cos_rom[i] = quantise($cos(TWO_PI * i / LENGTH));
		assign sin_rom[i] = quantise(-$sin(TWO_PI * i / LENGTH));
	end

	assign cos_part = cos_rom[index];
	assign sin_part = sin_rom[index];

endmodule : rotation_table

`default_nettype wire

// ### rtl/fft_ssr.sv
// Parallel-lane fixed-point transform: R samples per clock through a
// serial chain of radix-R stages with selectable word growth.
// Assumes producer and consumer run on mclk and exchange one R-lane word
// per time step with a valid and ready pair.
`timescale 1ns/1ps
`default_nettype none

module fft_ssr
	import fft_pkg::*;
#(
	parameter int          LANES         = DEF_LANES,
	parameter int          LENGTH        = DEF_LENGTH,
	parameter int          INTEGER_BITS  = DEF_INTEGER_BITS,
	parameter int          FRACTION_BITS = DEF_FRACTION_BITS,
	parameter scaling_type MODE          = capped_growth_mode,
	parameter int          ROT_BITS      = ROT_WORD_BITS,
	parameter int          ROT_INT       = ROT_INT_BITS,
	// Each part of a sample is a signed fixed-point word.
	localparam int         IN_W  = INTEGER_BITS + FRACTION_BITS,
	localparam int         LG    = radix_log2(LANES),
	localparam int         STAGES = (LG == 0) ? 1 : ceil_log2(LENGTH) / LG,
	localparam int         OUT_W = stage_width(MODE, IN_W, LG, STAGES)
)
(
	input  wire logic                    mclk,
	input  wire logic                    reset,
	input  wire logic                    ce,
	input  wire logic                    in_valid,
	output logic                         in_ready,
	input  wire logic [LANES*IN_W-1:0]   in_re,
	input  wire logic [LANES*IN_W-1:0]   in_im,
	output logic                         out_valid,
	input  wire logic                    out_ready,
	output logic [LANES*OUT_W-1:0]       out_re,
	output logic [LANES*OUT_W-1:0]       out_im,
	output logic                         out_last
);

	localparam int STEPS  = LENGTH / LANES;
	localparam int T_W    = ceil_log2(STEPS);
	localparam int IDX_W  = ceil_log2(LENGTH);
	localparam int MAX_W  = OUT_W;
	localparam int ACC_W  = MAX_W + ROT_BITS + LG + 2;
	localparam int ROT_FR = ROT_BITS - ROT_INT;
	localparam logic [T_W-1:0] LAST_STEP = T_W'(STEPS - 1);

	// Unsupported lane counts or lengths that are not a power of the lane
	// count leave the block permanently refusing input.
	localparam bit SHAPE_OK = (LG != 0) &&
		(LENGTH == (LANES ** STAGES));

	// Pipeline registers; index 0 is the input word, STAGES the output.
	// Every word is held sign-extended to the widest stage width.
	logic                    valid_q [0:STAGES];
	logic                    last_q  [0:STAGES];
	logic [T_W-1:0]          step_q  [0:STAGES];
	logic signed [MAX_W-1:0] re_q    [0:STAGES][LANES];
	logic signed [MAX_W-1:0] im_q    [0:STAGES][LANES];
	logic signed [MAX_W-1:0] re_d    [1:STAGES][LANES];
	logic signed [MAX_W-1:0] im_d    [1:STAGES][LANES];
	logic [T_W-1:0]          step_count_q;
	logic                    advance;
	logic                    take;

	// Rotation index for input lane m into output lane k at a time step.
	// The butterfly kernel and the inter-stage rotation are folded into
	// one lookup, which saves a second multiplier layer per stage.
	function automatic logic [IDX_W-1:0] rot_index(input int k,
		input int m, input logic [T_W-1:0] step, input int s);
		int raw;
		raw = k * m * STEPS + k * int'(step) * (LANES ** s);
		rot_index = IDX_W'(raw);
	endfunction : rot_index

	// Real part of a complex product.
	function automatic logic signed [ACC_W-1:0] mul_real(
		input logic signed [MAX_W-1:0]    xr,
		input logic signed [MAX_W-1:0]    xi,
		input logic signed [ROT_BITS-1:0] c,
		input logic signed [ROT_BITS-1:0] sn);
		mul_real = ACC_W'(xr * c) - ACC_W'(xi * sn);
	endfunction : mul_real

	// Imaginary part of a complex product.
	function automatic logic signed [ACC_W-1:0] mul_imag(
		input logic signed [MAX_W-1:0]    xr,
		input logic signed [MAX_W-1:0]    xi,
		input logic signed [ROT_BITS-1:0] c,
		input logic signed [ROT_BITS-1:0] sn);
		mul_imag = ACC_W'(xr * sn) + ACC_W'(xi * c);
	endfunction : mul_imag

	// The whole chain moves as one; a held output word stalls every stage.
	// The ready output is therefore a gate on out_ready, not a flop, to
	// avoid losing a word when the consumer drops ready.
	assign advance  = ce && SHAPE_OK && (!valid_q[STAGES] || out_ready);
	assign take     = advance && in_valid;
	assign in_ready = advance;

	// Time step counter over one block of N/R words.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			step_count_q <= '0;
		else if (take)
		begin
			if (step_count_q == LAST_STEP)
				step_count_q <= '0;
			else
				step_count_q <= step_count_q + 1'b1;
		end
	end

	// Valid, step and block-end markers travel alongside the data.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			for (int s = 0; s <= STAGES; s++)
			begin
				valid_q[s] <= 1'b0;
				last_q[s]  <= 1'b0;
				step_q[s]  <= '0;
			end
		end
		else if (advance)
		begin
			valid_q[0] <= in_valid;
			last_q[0]  <= in_valid && (step_count_q == LAST_STEP);
			step_q[0]  <= step_count_q;
			for (int s = 1; s <= STAGES; s++)
			begin
				valid_q[s] <= valid_q[s-1];
				last_q[s]  <= last_q[s-1];
				step_q[s]  <= step_q[s-1];
			end
		end
	end

	// Sample words: all lanes of a step are captured in one cycle.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			for (int s = 0; s <= STAGES; s++)
			begin
				for (int k = 0; k < LANES; k++)
				begin
					re_q[s][k] <= '0;
					im_q[s][k] <= '0;
				end
			end
		end
		else if (advance)
		begin
			for (int k = 0; k < LANES; k++)
			begin
				re_q[0][k] <= MAX_W'($signed(in_re[k*IN_W +: IN_W]));
				im_q[0][k] <= MAX_W'($signed(in_im[k*IN_W +: IN_W]));
			end
			for (int s = 1; s <= STAGES; s++)
			begin
				for (int k = 0; k < LANES; k++)
				begin
					re_q[s][k] <= re_d[s][k];
					im_q[s][k] <= im_d[s][k];
				end
			end
		end
	end

	// One radix-R stage per generate pass; stage s reads register s and
	// feeds register s+1.
	for (genvar s = 0; s < STAGES; s++)
	begin : stage
		localparam int W_I  = stage_width(MODE, IN_W, LG, s);
		localparam int W_O  = stage_width(MODE, IN_W, LG, s + 1);
		// Low bits dropped: the rotation fraction plus any scaling.
		localparam int DROP = ROT_FR + W_I + LG - W_O;

		logic signed [ROT_BITS-1:0] rc [LANES][LANES];
		logic signed [ROT_BITS-1:0] rs [LANES][LANES];

		for (genvar k = 0; k < LANES; k++)
		begin : out_lane
			logic signed [ACC_W-1:0] acc_re;
			logic signed [ACC_W-1:0] acc_im;
			logic signed [ACC_W-1:0] sh_re;
			logic signed [ACC_W-1:0] sh_im;

			for (genvar m = 0; m < LANES; m++)
			begin : in_lane
				rotation_table #(
					.LENGTH     (LENGTH),
					.TOTAL_BITS (ROT_BITS),
					.INT_BITS   (ROT_INT),
					.IDX_W      (IDX_W)
				) u_rot (
					.index    (rot_index(k, m, step_q[s], s)),
					.cos_part (rc[k][m]),
					.sin_part (rs[k][m])
				);
			end

			// Sum of R rotated inputs grows by log2(R) bits at most.
			always_comb
			begin
				acc_re = '0;
				acc_im = '0;
				for (int m = 0; m < LANES; m++)
				begin
					acc_re = acc_re + mul_real(re_q[s][m], im_q[s][m],
						rc[k][m], rs[k][m]);
					acc_im = acc_im + mul_imag(re_q[s][m], im_q[s][m],
						rc[k][m], rs[k][m]);
				end
			end

			// Truncating shift, then sign-extend the stage width. Unbounded
			// growth drops only the rotation fraction bits.
			assign sh_re = acc_re >>> DROP;
			assign sh_im = acc_im >>> DROP;
			assign re_d[s+1][k] = MAX_W'($signed(sh_re[W_O-1:0]));
			assign im_d[s+1][k] = MAX_W'($signed(sh_im[W_O-1:0]));
		end
	end

	// Output word: all lanes of one step, straight from the last register.
	for (genvar k = 0; k < LANES; k++)
	begin : pack
		assign out_re[k*OUT_W +: OUT_W] = re_q[STAGES][k][OUT_W-1:0];
		assign out_im[k*OUT_W +: OUT_W] = im_q[STAGES][k][OUT_W-1:0];
	end

	assign out_valid = valid_q[STAGES];
	assign out_last  = last_q[STAGES];

endmodule : fft_ssr

`default_nettype wire

// ### tb/fft_ssr_chk_sva.sv
// Port checker for fft_ssr: pipeline timing, stalls and block framing.
// Assumes one clock, mclk, and reset asynchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module fft_ssr_chk
#(
	parameter int LANES  = 4,
	parameter int LENGTH = 16,
	parameter int STAGES = 2,
	parameter int OUT_W  = 27
)
(
	input wire logic                   mclk,
	input wire logic                   reset,
	input wire logic                   ce,
	input wire logic                   in_valid,
	input wire logic                   in_ready,
	input wire logic                   out_valid,
	input wire logic                   out_ready,
	input wire logic [LANES*OUT_W-1:0] out_re,
	input wire logic [LANES*OUT_W-1:0] out_im,
	input wire logic                   out_last
);
	localparam int STEPS = LENGTH / LANES;
	logic [STAGES:0] tok_q;
	int              ocnt_q;
	logic            adv;
	// The whole chain moves only when nothing holds it back.
	assign adv = ce && (!out_valid || out_ready);
	// Marks of taken words, moved one stage per advancing edge.
	always_ff @(posedge mclk or posedge reset)
		if (reset)
			tok_q <= '0;
		else if (adv)
			tok_q <= {tok_q[STAGES-1:0], in_valid && in_ready};
	// Time step of the next word to leave, wrapping once per block.
	always_ff @(posedge mclk or posedge reset)
		if (reset)
			ocnt_q <= 0;
		else if (out_valid && out_ready && ce)
			ocnt_q <= (ocnt_q == STEPS - 1) ? 0 : ocnt_q + 1;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	sequence frozen;
		$stable(out_valid) && $stable(out_re) && $stable(out_im);
	endsequence
	sequence last_leaves;
		out_valid && out_last && out_ready && ce;
	endsequence
	AST_LATENCY: assert property (out_valid == tok_q[STAGES])
		else $error("Output word does not follow the stage count.");
	AST_HOLD: assert property (out_valid && !(ce && out_ready) |=>
		frozen ##0 $stable(out_last))
		else $error("Held output word changed.");
	AST_CE_FREEZE: assert property (!ce |-> !in_ready ##1 frozen)
		else $error("State moved with the clock enable low.");
	AST_STALL: assert property (out_valid && !out_ready |-> !in_ready)
		else $error("Input accepted while the output is held.");
	AST_ACCEPT: assert property (adv |-> in_ready)
		else $error("Input refused with a free pipeline.");
	AST_LAST: assert property (out_valid |->
		out_last == (ocnt_q == STEPS - 1))
		else $error("Last flag not on the final time step.");
	AST_LAST_VALID: assert property (out_last |-> out_valid)
		else $error("Last flag without a valid word.");
	AST_WRAP: assert property (last_leaves |=> !out_last)
		else $error("Block did not wrap to step zero.");
endmodule : fft_ssr_chk
bind fft_ssr fft_ssr_chk #(.LANES(LANES), .LENGTH(LENGTH), .STAGES(STAGES),
	.OUT_W(OUT_W)) chk (.mclk(mclk), .reset(reset), .ce(ce),
	.in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
	.out_ready(out_ready), .out_re(out_re), .out_im(out_im),
	.out_last(out_last));
`default_nettype wire

// ### tb/stream_sink.sv
// Consumer model: takes one whole R-lane word on each ready edge.
// Assumes ready is sampled on rising mclk, so it moves on falling edges.
`timescale 1ns/1ps
`default_nettype none
module stream_sink
(
	input wire logic mclk,
	input wire logic slow,
	output logic     out_ready
);
	// Slow mode stalls about a third of the cycles so words must wait.
	initial out_ready = 1'h1;
	always @(negedge mclk)
		out_ready <= slow ? ($urandom % 3 != 0) : 1'h1;
endmodule : stream_sink
`default_nettype wire

// ### tb/fft_ssr_test.sv
// Testbench for fft_ssr: zero and random blocks with bubbles and stalls,
// every output word checked against a reference of the stage formula.
// Assumes stream_sink as consumer and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module fft_ssr_test
	import fft_pkg::*;
;
	localparam int LANES = 4;
	localparam int STEPS = 4;
	localparam int IN_W  = 24;
	// Width 24 grows to 26, then the cap stops it at the multiplier's 27.
	localparam int EXP_W = 27;
	localparam int W_MID = 26;
	localparam int LENGTH = 16;
	localparam int LG = radix_log2(LANES);
	localparam int FRAC_ROT = ROT_WORD_BITS - ROT_INT_BITS;
	localparam real ROT_SCALE = 2.0 ** (ROT_WORD_BITS - ROT_INT_BITS);
	logic                   mclk, reset, ce, in_valid, in_ready, slow;
	logic                   out_valid, out_ready, out_last;
	logic [LANES*IN_W-1:0]  in_re, in_im;
	logic [LANES*EXP_W-1:0] out_re, out_im;
	logic [2*LANES*EXP_W:0] note;
	logic [2*LANES*EXP_W:0] exp_q[$];
	int                     fails, check_count, cycles;
	fft_ssr #(.LANES(LANES), .LENGTH(LENGTH), .INTEGER_BITS(12),
		.FRACTION_BITS(12), .MODE(capped_growth_mode)) dut (.mclk(mclk),
		.reset(reset), .ce(ce), .in_valid(in_valid), .in_ready(in_ready),
		.in_re(in_re), .in_im(in_im), .out_valid(out_valid),
		.out_ready(out_ready), .out_re(out_re), .out_im(out_im),
		.out_last(out_last));
	stream_sink sink (.mclk(mclk), .slow(slow), .out_ready(out_ready));
	initial
	begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	task cmp_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_flag
	task cmp_data(input logic [LANES*EXP_W-1:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_data
	task cmp_num(input int got, input int exp);
		check_count++;
		if (got != exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_num
	task close_out;
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	// Rounds to nearest, halves away from zero.
	function automatic longint rnd(input real v);
		rnd = $rtoi(v + ((v < 0.0) ? -0.5 : 0.5));
	endfunction : rnd
	// Keeps the low w bits of x as a signed value, as a stage register does.
	function automatic longint wrap(input longint x, input int w);
		wrap = (x <<< (64 - w)) >>> (64 - w);
	endfunction : wrap
	// Expected output word: each stage sums rotated lanes, floors away the
	// rotation fraction plus the growth the cap refuses, then wraps.
	function automatic logic [2*LANES*EXP_W-1:0] ref_word(
		input logic [LANES*IN_W-1:0] xr,
		input logic [LANES*IN_W-1:0] xi,
		input int                    t);
		longint                 ar [LANES];
		longint                 ai [LANES];
		longint                 br [LANES];
		longint                 bi [LANES];
		longint                 c, sn;
		int                     idx, wi, wo;
		real                    v;
		logic [LANES*EXP_W-1:0] yr, yi;
		for (int k = 0; k < LANES; k++)
		begin
			ar[k] = longint'($signed(xr[k*IN_W +: IN_W]));
			ai[k] = longint'($signed(xi[k*IN_W +: IN_W]));
		end
		for (int s = 0; s < 2; s++)
		begin
			wi = (s == 0) ? IN_W : W_MID;
			wo = (s == 0) ? W_MID : EXP_W;
			for (int k = 0; k < LANES; k++)
			begin
				br[k] = 0;
				bi[k] = 0;
				for (int m = 0; m < LANES; m++)
				begin
					idx = (k * m * STEPS + k * t * (LANES ** s)) % LENGTH;
					v = TWO_PI * idx / LENGTH;
					c = rnd(ROT_SCALE * $cos(v));
					sn = rnd(-ROT_SCALE * $sin(v));
					br[k] += ar[m] * c - ai[m] * sn;
					bi[k] += ar[m] * sn + ai[m] * c;
				end
			end
			for (int k = 0; k < LANES; k++)
			begin
				ar[k] = wrap(br[k] >>> (FRAC_ROT + wi + LG - wo), wo);
				ai[k] = wrap(bi[k] >>> (FRAC_ROT + wi + LG - wo), wo);
			end
		end
		for (int k = 0; k < LANES; k++)
		begin
			yr[k*EXP_W +: EXP_W] = EXP_W'(ar[k]);
			yi[k*EXP_W +: EXP_W] = EXP_W'(ai[k]);
		end
		ref_word = {yr, yi};
	endfunction : ref_word
	// One block of STEPS words; a word is held until it is taken.
	task send_block(input bit zero, input bit noisy);
		logic took;
		for (int t = 0; t < STEPS; t++)
		begin
			@(negedge mclk);
			while (noisy && $urandom % 4 == 0)
			begin
				in_valid = 1'h0;
				@(negedge mclk);
			end
			in_valid = 1'h1;
			in_re = zero ? '0 : {$urandom, $urandom, $urandom};
			in_im = zero ? '0 : {$urandom, $urandom, $urandom};
			took = 1'h0;
			while (!took)
			begin
				ce = !(noisy && $urandom % 5 == 0);
				#1;
				took = in_ready;
				if (!took)
					@(negedge mclk);
			end
			exp_q.push_back({t == STEPS - 1, ref_word(in_re, in_im, t)});
		end
	endtask : send_block
	// Words are judged while they wait for the edge that moves them on.
	always @(negedge mclk)
	begin
		#2;
		if (!reset && out_valid === 1'h1 && out_ready && ce)
		begin
			if (exp_q.size() == 0)
				cmp_flag(out_valid, 1'h0);
			else
			begin
				note = exp_q.pop_front();
				cmp_flag(out_last, note[2*LANES*EXP_W]);
				cmp_data(out_re, note[2*LANES*EXP_W-1:LANES*EXP_W]);
				cmp_data(out_im, note[LANES*EXP_W-1:0]);
			end
		end
	end
	// A hang ends the run well past the fewer than a hundred cycles needed.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		void'($urandom(40));
		fails = 0;
		check_count = 0;
		cycles = 0;
		{reset, ce, in_valid, slow} = 4'h8;
		in_re = '0;
		in_im = '0;
		repeat (20) @(posedge mclk);
		@(negedge mclk) reset = 1'h0;
		cmp_num($bits(dut.out_re), LANES * EXP_W);
		send_block(1'b1, 1'b0);
		send_block(1'b0, 1'b0);
		slow = 1'h1;
		repeat (3) send_block(1'b0, 1'b1);
		send_block(1'b1, 1'b1);
		@(negedge mclk) in_valid = 1'h0;
		for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge mclk);
		cmp_num(exp_q.size(), 0);
		close_out();
	end
endmodule : fft_ssr_test
`default_nettype wire
